// ===== logic/mac_port_pkg.sv
package mac_port_pkg;

   // Interface flavour selected on both ends
   typedef enum logic [1:0] {
      MODE_MII = 2'h0,
      MODE_RMII = 2'h1,
      MODE_RGMII = 2'h2
   } port_mode_type;

   // Strap capture sequence of the device end, one-hot
   typedef enum logic [2:0] {
      STRAP_WAIT = 3'b001,
      STRAP_TAKE = 3'b010,
      STRAP_RUN = 3'b100
   } strap_state_type;

   // Clock rates in Hz
   localparam int CLK_HZ = 200_000_000;
   localparam int FAST_HZ = 25_000_000;
   localparam int SLOW_HZ = 2_500_000;
   localparam int REF_HZ = 50_000_000;

   // Half periods of the link clocks in system clock cycles
   localparam logic [6:0] HALF_FAST = 7'(CLK_HZ / FAST_HZ / 2);
   localparam logic [6:0] HALF_SLOW = 7'(CLK_HZ / SLOW_HZ / 2);
   localparam logic [6:0] HALF_REF = 7'(CLK_HZ / REF_HZ / 2);

   // Strap pull levels: data pins pulled down, collision pin pulled up
   localparam logic [4:0] STRAP_DEFAULT = 5'h01;
   // Settle count that ends the wait state, one cycle short of its length, so the strap synchronisers settle
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // Half period for the selected mode and speed
   function automatic logic [6:0] half_count(input port_mode_type mode, input logic slow);
      if (mode == MODE_RMII) begin
         return HALF_REF;
      end else if (slow) begin
         return HALF_SLOW;
      end else begin
         return HALF_FAST;
      end
   endfunction

endpackage

// ===== logic/mac_link_if.sv
`timescale 1ns/1ps
interface mac_link_if;
   import mac_port_pkg::*;

   // Two-way transmit clock pin, both ends may drive it
   logic dev_tx_clk_out;
   logic dev_tx_clk_oe;
   logic mac_tx_clk_out;
   logic mac_tx_clk_oe;
   logic tx_clk;
   // Transmit enable or control, and transmit data
   logic tx_ctrl;
   logic [3:0] txd;
   // Receive side outputs of the device
   logic rx_clk;
   logic rx_ctrl;
   logic rx_er;
   logic [3:0] rxd_out;
   logic rxd_oe;
   logic col_out;
   logic col_oe;
   logic crs;
   logic ref_clk;
   // Board strap levels, set by the bench
   logic [4:0] strap_level;
   logic [3:0] rxd;
   logic col;

   // Device drive wins; an undriven clock pin reads low through its pull-down
   assign tx_clk = dev_tx_clk_oe ? dev_tx_clk_out : (mac_tx_clk_oe ? mac_tx_clk_out : 1'b0);
   // Undriven strap pins read their board level
   assign rxd = rxd_oe ? rxd_out : strap_level[4:1];
   assign col = col_oe ? col_out : strap_level[0];

   modport phy (
      output dev_tx_clk_out, dev_tx_clk_oe, rx_clk, rx_ctrl, rx_er, rxd_out, rxd_oe,
      output col_out, col_oe, crs, ref_clk,
      input tx_clk, tx_ctrl, txd, rxd, col
   );

   modport mac (
      output mac_tx_clk_out, mac_tx_clk_oe, tx_ctrl, txd,
      input tx_clk, rx_clk, rx_ctrl, rx_er, rxd, col, crs, ref_clk
   );

endinterface

// ===== logic/clk_div_gen.sv
`timescale 1ns/1ps
module clk_div_gen
   import mac_port_pkg::*;
(
   input wire logic clk_in, // System clock
   input wire logic rst_n_in, // Asynchronous reset, active low
   input wire logic [6:0] half_in, // Half period in cycles
   output logic clk_out, // Divided clock
   output logic rise_out, // Pulse in the cycle clk_out goes high
   output logic fall_out // Pulse in the cycle clk_out goes low
);

   logic [6:0] cnt_r; // Half period counter
   logic [6:0] cnt_nxt;
   logic clk_r; // Divided clock level
   logic clk_nxt;
   logic rise_r; // Edge pulses aligned with clk_r
   logic rise_nxt;
   logic fall_r;
   logic fall_nxt;

   // Toggle at the end of each half period; >= keeps a speed change from overrunning
   always_comb begin
      cnt_nxt = cnt_r + 7'h01;
      clk_nxt = clk_r;
      rise_nxt = 1'b0;
      fall_nxt = 1'b0;
      if (cnt_r >= half_in - 7'h01) begin
         cnt_nxt = 7'h00;
         clk_nxt = ~clk_r;
         rise_nxt = ~clk_r;
         fall_nxt = clk_r;
      end
   end

   // Register the divider state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= 7'h00;
         clk_r <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         clk_r <= clk_nxt;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
      end
   end

   assign clk_out = clk_r;
   assign rise_out = rise_r;
   assign fall_out = fall_r;

endmodule

// ===== logic/phy_port_end.sv
`timescale 1ns/1ps
module phy_port_end
   import mac_port_pkg::*;
(
   input wire logic clk_in, // System clock, 200 MHz
   input wire logic rst_n_in, // Asynchronous reset, active low
   input wire port_mode_type mode_in, // Interface flavour
   input wire logic slow_in, // High for 10 Mbps in MII and RGMII; RMII keeps the reference clock at either setting
   input wire logic full_duplex_in, // High for full duplex
   input wire logic line_rx_dv_in, // Line nibble is valid
   input wire logic [3:0] line_rx_data_in, // Line nibble
   input wire logic line_rx_err_in, // Line nibble carries an error symbol
   input wire logic line_rx_active_in, // Receive medium not idle
   output logic line_rx_take_out, // Line nibble taken this cycle
   output logic line_tx_valid_out, // Transmit nibble pulse
   output logic [3:0] line_tx_data_out, // Transmit nibble
   output logic line_tx_err_out, // Transmit error with the nibble
   output logic [4:0] strap_addr_out, // Latched management address
   output logic strap_done_out, // Straps latched, pins driven
   mac_link_if.phy link // Link to the MAC
);
   logic div_clk, div_rise, div_fall; // Locally made link clock and its edge pulses
   logic [10:0] pin_s1_r, pin_s2_r; // First and second synchroniser stages
   logic s_txc, s_txctl, txc_prev_r; // Synchronised clock and control, last clock level
   logic [3:0] s_txd; // Synchronised transmit data
   logic [4:0] s_strap; // Synchronised strap levels
   logic ext_rise, ext_fall; // Edges of the MAC-supplied clock
   logic is_rmii, is_rgmii, run; // Mode decodes; run once the straps are taken
   // Reference-derived divider keeps every made clock in fixed phase with clk_in
   clk_div_gen u_div (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .half_in(half_count(mode_in, slow_in)),
      .clk_out(div_clk),
      .rise_out(div_rise),
      .fall_out(div_fall)
   );
   // Two-flop synchronisers for every pin from the MAC and for the straps
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_s1_r <= 11'h000;
         pin_s2_r <= 11'h000;
         txc_prev_r <= 1'b0;
      end else begin
         pin_s1_r <= {link.tx_clk, link.tx_ctrl, link.txd, link.rxd, link.col};
         pin_s2_r <= pin_s1_r;
         txc_prev_r <= s_txc;
      end
   end

   assign {s_txc, s_txctl, s_txd, s_strap} = pin_s2_r;
   // Edges of the MAC-supplied clock, RGMII only
   assign ext_rise = s_txc & ~txc_prev_r;
   assign ext_fall = ~s_txc & txc_prev_r;
   assign is_rmii = (mode_in == MODE_RMII);
   assign is_rgmii = (mode_in == MODE_RGMII);

   // Strap capture group
   strap_state_type strap_r, strap_nxt; // Capture sequence
   logic [1:0] settle_r, settle_nxt; // Synchroniser settle count
   logic [4:0] addr_r, addr_nxt; // Latched address
   // Strap pins stay undriven until the settled strap levels are latched
   always_comb begin
      strap_nxt = strap_r;
      settle_nxt = settle_r;
      addr_nxt = addr_r;
      unique case (strap_r)
         STRAP_WAIT: begin
            settle_nxt = settle_r + 2'h1;
            if (settle_r == STRAP_SETTLE) begin
               strap_nxt = STRAP_TAKE;
            end
         end
         STRAP_TAKE: begin
            addr_nxt = s_strap;
            strap_nxt = STRAP_RUN;
         end
         STRAP_RUN: strap_nxt = STRAP_RUN;
         default: strap_nxt = STRAP_WAIT; // Illegal codes restart the capture
      endcase
   end
   // Register the strap state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strap_r <= STRAP_WAIT;
         settle_r <= 2'h0;
         addr_r <= STRAP_DEFAULT;
      end else begin
         strap_r <= strap_nxt;
         settle_r <= settle_nxt;
         addr_r <= addr_nxt;
      end
   end

   assign run = (strap_r == STRAP_RUN);

   // Transmit capture group
   logic tx_pair_r, tx_pair_nxt; // RMII: low dibit already held
   logic [1:0] tx_low_r, tx_low_nxt; // RMII low dibit
   logic tx_en_r, tx_en_nxt; // Transmit medium active
   logic [3:0] tx_hold_r, tx_hold_nxt; // RGMII nibble waiting for its error half
   logic tx_valid_r, tx_valid_nxt, tx_err_r, tx_err_nxt; // Line-side pulse and error
   logic [3:0] tx_data_r, tx_data_nxt; // Line-side nibble
   // Sample the MAC pins on the rising edge; RGMII also on the falling edge
   always_comb begin
      tx_pair_nxt = tx_pair_r;
      tx_low_nxt = tx_low_r;
      tx_en_nxt = tx_en_r;
      tx_hold_nxt = tx_hold_r;
      tx_valid_nxt = 1'b0;
      tx_data_nxt = tx_data_r;
      tx_err_nxt = tx_err_r;
      if (!run) begin
         tx_en_nxt = 1'b0;
         tx_pair_nxt = 1'b0;
      end else if (is_rgmii) begin
         if (ext_rise) begin
            tx_en_nxt = s_txctl;
            tx_hold_nxt = s_txd;
         end else if (ext_fall && tx_en_r) begin
            tx_valid_nxt = 1'b1;
            tx_data_nxt = tx_hold_r;
            tx_err_nxt = s_txctl;
         end
      end else if (div_rise) begin
         tx_en_nxt = s_txctl;
         tx_err_nxt = 1'b0;
         if (!s_txctl) begin
            tx_pair_nxt = 1'b0;
         end else if (!is_rmii) begin
            tx_valid_nxt = 1'b1;
            tx_data_nxt = s_txd;
         end else if (!tx_pair_r) begin
            // First dibit is the low half of the nibble
            tx_low_nxt = s_txd[1:0];
            tx_pair_nxt = 1'b1;
         end else begin
            tx_valid_nxt = 1'b1;
            tx_data_nxt = {s_txd[1:0], tx_low_r};
            tx_pair_nxt = 1'b0;
         end
      end
   end

   // Register the transmit state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_pair_r <= 1'b0;
         tx_low_r <= 2'h0;
         tx_en_r <= 1'b0;
         tx_hold_r <= 4'h0;
         tx_valid_r <= 1'b0;
         tx_data_r <= 4'h0;
         tx_err_r <= 1'b0;
      end else begin
         tx_pair_r <= tx_pair_nxt;
         tx_low_r <= tx_low_nxt;
         tx_en_r <= tx_en_nxt;
         tx_hold_r <= tx_hold_nxt;
         tx_valid_r <= tx_valid_nxt;
         tx_data_r <= tx_data_nxt;
         tx_err_r <= tx_err_nxt;
      end
   end

   // Receive drive group
   logic rx_phase_r, rx_phase_nxt; // RMII: upper dibit pending
   logic [1:0] rx_upper_r, rx_upper_nxt; // RMII upper dibit
   logic rx_dv_r, rx_dv_nxt, rx_er_r, rx_er_nxt; // Data valid and error pins
   logic rx_ctrl_r, rx_ctrl_nxt; // RGMII control pin
   logic [3:0] rxd_r, rxd_nxt; // Data pins
   logic crs_r, crs_nxt, col_r, col_nxt; // Carrier and collision pins
   logic [3:0] rx_word; // Nibble after error corruption
   // Data changes on the falling edge so the MAC samples it settled on the rise
   assign line_rx_take_out = run & div_fall & ~(is_rmii & rx_phase_r);
   // Inverting an errored nibble breaks the frame check, so the MAC may ignore the error pin
   assign rx_word = line_rx_err_in ? ~line_rx_data_in : line_rx_data_in;

   always_comb begin
      rx_phase_nxt = rx_phase_r;
      rx_upper_nxt = rx_upper_r;
      rx_dv_nxt = rx_dv_r;
      rx_er_nxt = rx_er_r;
      rx_ctrl_nxt = rx_ctrl_r;
      rxd_nxt = rxd_r;
      if (line_rx_take_out) begin
         rx_dv_nxt = line_rx_dv_in;
         rx_er_nxt = line_rx_dv_in & line_rx_err_in;
         rx_ctrl_nxt = line_rx_dv_in;
         if (!line_rx_dv_in) begin
            rxd_nxt = 4'h0;
         end else if (is_rmii) begin
            rxd_nxt = {2'h0, rx_word[1:0]};
            rx_upper_nxt = rx_word[3:2];
            rx_phase_nxt = 1'b1;
         end else begin
            rxd_nxt = rx_word;
         end
      end else if (run && div_fall) begin
         // Second half of an RMII nibble
         rxd_nxt = {2'h0, rx_upper_r};
         rx_phase_nxt = 1'b0;
      end else if (run && div_rise && is_rgmii) begin
         rx_ctrl_nxt = rx_er_r;
      end
      // MII senses both media; RMII merges carrier with data valid
      crs_nxt = is_rmii ? (line_rx_active_in | rx_dv_r) : (line_rx_active_in | tx_en_r);
      col_nxt = ~full_duplex_in & line_rx_active_in & tx_en_r;
   end

   // Register the receive outputs
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_phase_r <= 1'b0;
         rx_upper_r <= 2'h0;
         rx_dv_r <= 1'b0;
         rx_er_r <= 1'b0;
         rx_ctrl_r <= 1'b0;
         rxd_r <= 4'h0;
         crs_r <= 1'b0;
         col_r <= 1'b0;
      end else begin
         rx_phase_r <= rx_phase_nxt;
         rx_upper_r <= rx_upper_nxt;
         rx_dv_r <= rx_dv_nxt;
         rx_er_r <= rx_er_nxt;
         rx_ctrl_r <= rx_ctrl_nxt;
         rxd_r <= rxd_nxt;
         crs_r <= crs_nxt;
         col_r <= col_nxt;
      end
   end

   // Pin drive; the clock pin stays a low output until straps are taken
   assign link.dev_tx_clk_oe = ~run | (mode_in == MODE_MII);
   assign link.dev_tx_clk_out = run & div_clk;
   assign link.rx_clk = ~is_rmii & div_clk;
   assign link.ref_clk = is_rmii & div_clk;
   assign link.rx_ctrl = is_rgmii ? rx_ctrl_r : rx_dv_r;
   assign link.rx_er = ~is_rgmii & rx_er_r;
   assign link.rxd_out = rxd_r;
   assign link.rxd_oe = run;
   assign link.col_out = col_r;
   assign link.col_oe = run & ~is_rmii;
   assign link.crs = ~is_rgmii & crs_r;
   assign line_tx_valid_out = tx_valid_r;
   assign line_tx_data_out = tx_data_r;
   assign line_tx_err_out = tx_err_r;
   assign strap_addr_out = addr_r;
   assign strap_done_out = run;

endmodule

// ===== logic/mac_port_end.sv
`timescale 1ns/1ps
module mac_port_end
   import mac_port_pkg::*;
(
   input wire logic clk_in, // System clock, 200 MHz
   input wire logic rst_n_in, // Asynchronous reset, active low
   input wire port_mode_type mode_in, // Interface flavour, same as the device
   input wire logic slow_in, // High for 10 Mbps in MII and RGMII; RMII keeps the reference clock at either setting
   input wire logic tx_valid_in, // Nibble offered for transmit
   input wire logic [3:0] tx_data_in, // Transmit nibble
   input wire logic tx_err_in, // Transmit error, RGMII only
   output logic tx_ready_out, // Nibble taken this cycle
   output logic rx_valid_out, // Received nibble pulse
   output logic [3:0] rx_data_out, // Received nibble
   output logic rx_err_out, // Error with the nibble
   output logic crs_out, // Synchronised carrier pin
   output logic col_out, // Synchronised collision pin
   mac_link_if.mac link // Link to the device
);

   logic div_clk; // RGMII transmit clock made here
   logic div_rise;
   logic div_fall;
   logic [10:0] pin_s1_r; // First synchroniser stage
   logic [10:0] pin_s2_r; // Second synchroniser stage
   logic [2:0] clk_prev_r; // Last levels of the three incoming clocks
   logic s_txc;
   logic s_rxc;
   logic s_ref;
   logic s_rxctl;
   logic s_rxer;
   logic [3:0] s_rxd;
   logic s_crs;
   logic s_col;
   logic is_rmii;
   logic is_rgmii;
   logic drive_evt; // Time to change the transmit pins
   logic samp_rise; // Time to sample receive pins
   logic samp_fall;

   clk_div_gen u_div (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .half_in(half_count(mode_in, slow_in)),
      .clk_out(div_clk),
      .rise_out(div_rise),
      .fall_out(div_fall)
   );

   // Two-flop synchronisers for every pin from the device
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_s1_r <= 11'h000;
         pin_s2_r <= 11'h000;
         clk_prev_r <= 3'h0;
      end else begin
         pin_s1_r <= {link.tx_clk, link.rx_clk, link.ref_clk, link.rx_ctrl, link.rx_er,
                      link.rxd, link.crs, link.col};
         pin_s2_r <= pin_s1_r;
         clk_prev_r <= {s_txc, s_rxc, s_ref};
      end
   end

   assign {s_txc, s_rxc, s_ref, s_rxctl, s_rxer, s_rxd, s_crs, s_col} = pin_s2_r;
   assign is_rmii = (mode_in == MODE_RMII);
   assign is_rgmii = (mode_in == MODE_RGMII);

   // Pins change on a falling edge and are sampled on a rising one; in RGMII the control pin also changes on the rise and is sampled on the fall
   always_comb begin
      if (is_rgmii) begin
         drive_evt = div_fall;
         samp_rise = s_rxc & ~clk_prev_r[1];
         samp_fall = ~s_rxc & clk_prev_r[1];
      end else if (is_rmii) begin
         drive_evt = ~s_ref & clk_prev_r[0];
         samp_rise = s_ref & ~clk_prev_r[0];
         samp_fall = 1'b0;
      end else begin
         drive_evt = ~s_txc & clk_prev_r[2];
         samp_rise = s_rxc & ~clk_prev_r[1];
         samp_fall = 1'b0;
      end
   end

   // Transmit group
   logic tx_phase_r; // RMII: upper dibit pending
   logic tx_phase_nxt;
   logic [1:0] tx_upper_r;
   logic [1:0] tx_upper_nxt;
   logic tx_ctrl_r;
   logic tx_ctrl_nxt;
   logic tx_er_r; // RGMII error for the falling half
   logic tx_er_nxt;
   logic [3:0] txd_r;
   logic [3:0] txd_nxt;

   assign tx_ready_out = drive_evt & tx_valid_in & ~(is_rmii & tx_phase_r);

   always_comb begin
      tx_phase_nxt = tx_phase_r;
      tx_upper_nxt = tx_upper_r;
      tx_ctrl_nxt = tx_ctrl_r;
      tx_er_nxt = tx_er_r;
      txd_nxt = txd_r;
      if (drive_evt && is_rmii && tx_phase_r) begin
         txd_nxt = {2'h0, tx_upper_r};
         tx_phase_nxt = 1'b0;
      end else if (drive_evt) begin
         tx_ctrl_nxt = tx_valid_in;
         tx_er_nxt = tx_valid_in & tx_err_in;
         txd_nxt = tx_valid_in ? tx_data_in : 4'h0;
         if (tx_valid_in && is_rmii) begin
            txd_nxt = {2'h0, tx_data_in[1:0]};
            tx_upper_nxt = tx_data_in[3:2];
            tx_phase_nxt = 1'b1;
         end
      end else if (div_rise && is_rgmii) begin
         tx_ctrl_nxt = tx_er_r;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_phase_r <= 1'b0;
         tx_upper_r <= 2'h0;
         tx_ctrl_r <= 1'b0;
         tx_er_r <= 1'b0;
         txd_r <= 4'h0;
      end else begin
         tx_phase_r <= tx_phase_nxt;
         tx_upper_r <= tx_upper_nxt;
         tx_ctrl_r <= tx_ctrl_nxt;
         tx_er_r <= tx_er_nxt;
         txd_r <= txd_nxt;
      end
   end

   // Receive group
   logic rx_pair_r; // RMII: low dibit held
   logic rx_pair_nxt;
   logic [1:0] rx_low_r;
   logic [1:0] rx_low_nxt;
   logic rx_pend_r; // RGMII nibble waits for its error half
   logic rx_pend_nxt;
   logic rx_valid_r;
   logic rx_valid_nxt;
   logic [3:0] rx_data_r;
   logic [3:0] rx_data_nxt;
   logic rx_err_r;
   logic rx_err_nxt;

   always_comb begin
      rx_pair_nxt = rx_pair_r;
      rx_low_nxt = rx_low_r;
      rx_pend_nxt = rx_pend_r;
      rx_valid_nxt = 1'b0;
      rx_data_nxt = rx_data_r;
      rx_err_nxt = rx_err_r;
      if (samp_rise) begin
         if (!s_rxctl) begin
            rx_pair_nxt = 1'b0;
            rx_pend_nxt = 1'b0;
         end else if (is_rgmii) begin
            rx_pend_nxt = 1'b1;
            rx_data_nxt = s_rxd;
         end else if (!is_rmii) begin
            rx_valid_nxt = 1'b1;
            rx_data_nxt = s_rxd;
            rx_err_nxt = s_rxer;
         end else if (!rx_pair_r) begin
            rx_low_nxt = s_rxd[1:0];
            rx_pair_nxt = 1'b1;
         end else begin
            rx_valid_nxt = 1'b1;
            rx_data_nxt = {s_rxd[1:0], rx_low_r};
            rx_err_nxt = s_rxer;
            rx_pair_nxt = 1'b0;
         end
      end else if (samp_fall && rx_pend_r) begin
         rx_valid_nxt = 1'b1;
         rx_err_nxt = s_rxctl;
         rx_pend_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_pair_r <= 1'b0;
         rx_low_r <= 2'h0;
         rx_pend_r <= 1'b0;
         rx_valid_r <= 1'b0;
         rx_data_r <= 4'h0;
         rx_err_r <= 1'b0;
      end else begin
         rx_pair_r <= rx_pair_nxt;
         rx_low_r <= rx_low_nxt;
         rx_pend_r <= rx_pend_nxt;
         rx_valid_r <= rx_valid_nxt;
         rx_data_r <= rx_data_nxt;
         rx_err_r <= rx_err_nxt;
      end
   end

   // The clock pin is ours only in RGMII
   assign link.mac_tx_clk_oe = is_rgmii;
   assign link.mac_tx_clk_out = is_rgmii & div_clk;
   assign link.tx_ctrl = tx_ctrl_r;
   assign link.txd = txd_r;
   assign rx_valid_out = rx_valid_r;
   assign rx_data_out = rx_data_r;
   assign rx_err_out = rx_err_r;
   assign crs_out = s_crs;
   assign col_out = s_col;

endmodule

// ===== bench/mac_link_properties.sv
`timescale 1ns/1ps
module mac_link_properties
   import mac_port_pkg::*;
(
   input wire logic clk_in, // System clock
   input wire logic rst_n_in, // Reset, active low
   input wire port_mode_type mode_in, // Interface flavour
   input wire logic slow_in, // High for 10 Mbps
   input wire logic full_duplex_in, // High for full duplex
   input wire logic tx_clk, // Resolved transmit clock pin
   input wire logic dev_tx_clk_oe, // Device drives transmit clock
   input wire logic rx_clk, // Receive clock pin
   input wire logic rx_er, // Receive error pin
   input wire logic crs, // Carrier pin
   input wire logic rxd_oe, // Device drives data pins
   input wire logic col_oe, // Device drives collision pin
   input wire logic col, // Resolved collision pin
   input wire logic ref_clk // Shared reference clock pin
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Four cycles high then low, one half of a 25 MHz clock
   sequence s_fast(s);
      s[*4] ##1 !s;
   endsequence
   // Strap pins must stay released while the levels settle
   sequence s_quiet;
      (!rxd_oe)[*3];
   endsequence
   a_clk_low_release: assert property ($rose(rst_n_in) |-> dev_tx_clk_oe && !tx_clk)
      else $error("transmit clock not driven low at release");
   a_straps_quiet: assert property ($rose(rst_n_in) |-> s_quiet)
      else $error("data pins driven before straps settle");
   a_pins_driven: assert property ($rose(rst_n_in) |-> ##[3:8] rxd_oe)
      else $error("data pins never driven after release");
   a_tx_clk_half: assert property (mode_in == MODE_MII && !slow_in && $rose(tx_clk)
      |-> s_fast(tx_clk))
      else $error("transmit clock half period wrong");
   a_rx_clk_half: assert property (mode_in != MODE_RMII && !slow_in && $rose(rx_clk)
      |-> s_fast(rx_clk))
      else $error("receive clock half period wrong");
   a_rmii_no_rxclk: assert property (mode_in == MODE_RMII |-> !rx_clk)
      else $error("receive clock runs in reduced mode");
   a_ref_half: assert property (mode_in == MODE_RMII && $rose(ref_clk)
      |-> ref_clk[*2] ##1 !ref_clk)
      else $error("reference clock half period wrong");
   a_rgmii_unused: assert property (mode_in == MODE_RGMII |-> !rx_er && !crs)
      else $error("unused pins active in reduced-pin gigabit mode");
   a_col_full_dup: assert property (mode_in != MODE_RMII && col_oe && full_duplex_in
      |-> !col)
      else $error("collision raised in full duplex");
endmodule

// ===== bench/phy_mac_side_mii_rmii_rgmii_port_tb.sv
`timescale 1ns/1ps
module phy_mac_side_mii_rmii_rgmii_port_tb;
   import mac_port_pkg::*;
   logic clk_in, rst_n_in, slow, fdx, rdv, rerr, take, ltv, done, tv, trdy, rv;
   logic lte, terr, re, crs_o, col_o;
   port_mode_type mode;
   logic [3:0] rdat, ltd, td, rd;
   logic [4:0] addr;
   logic [4:0] rq[$]; // Expected error bit and nibble at the MAC
   logic [4:0] tq[$]; // Expected error bit and nibble at the line
   int n_errors, compares;
   mac_link_if link();
   phy_port_end i_phy_port_end(.clk_in(clk_in), .rst_n_in(rst_n_in), .mode_in(mode),
      .slow_in(slow), .full_duplex_in(fdx), .line_rx_dv_in(rdv), .line_rx_data_in(rdat),
      .line_rx_err_in(rerr), .line_rx_active_in(rdv), .line_rx_take_out(take),
      .line_tx_valid_out(ltv), .line_tx_data_out(ltd), .line_tx_err_out(lte),
      .strap_addr_out(addr), .strap_done_out(done), .link(link));
   mac_port_end i_mac_port_end(.clk_in(clk_in), .rst_n_in(rst_n_in), .mode_in(mode),
      .slow_in(slow), .tx_valid_in(tv), .tx_data_in(td), .tx_err_in(terr),
      .tx_ready_out(trdy), .rx_valid_out(rv), .rx_data_out(rd), .rx_err_out(re),
      .crs_out(crs_o), .col_out(col_o), .link(link));
   mac_link_properties i_mac_link_properties(.clk_in(clk_in), .rst_n_in(rst_n_in),
      .mode_in(mode), .slow_in(slow), .full_duplex_in(fdx), .tx_clk(link.tx_clk),
      .dev_tx_clk_oe(link.dev_tx_clk_oe), .rx_clk(link.rx_clk), .rx_er(link.rx_er),
      .crs(link.crs), .rxd_oe(link.rxd_oe), .col_oe(link.col_oe), .col(link.col),
      .ref_clk(link.ref_clk));
   // 200 MHz system clock
   always #2.5 clk_in = ~clk_in;
   // Compare and count, report at once on a mismatch
   task chk(input logic [4:0] got, input logic [4:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // Two bursts of line nibbles; error nibbles come out inverted
   task automatic run_rx();
      logic [3:0] d;
      logic e;
      repeat (2) begin
         repeat (8) begin
            d = 4'($urandom);
            e = ($urandom % 5) == 0;
            rdv = 1'b1;
            rdat = d;
            rerr = e;
            do @(negedge clk_in); while (!take);
            rq.push_back({e, e ? ~d : d});
            @(posedge clk_in);
            #1;
         end
         rdv = 1'b0;
         repeat (60) @(posedge clk_in);
         #1;
      end
   endtask
   // Two bursts of MAC nibbles, 60 cycles apart
   task automatic run_tx();
      logic [3:0] d;
      logic e;
      repeat (2) begin
         repeat (8) begin
            d = 4'($urandom);
            tv = 1'b1;
            td = d;
            e = ($urandom % 4) == 0;
            terr = e;
            do @(negedge clk_in); while (!trdy);
            tq.push_back({e & (mode == MODE_RGMII), d});
            @(posedge clk_in);
            #1;
         end
         tv = 1'b0;
         repeat (60) @(posedge clk_in);
         #1;
      end
   endtask
   // Results are taken at the falling edge, where pulses are settled
   always @(negedge clk_in) begin
      if (rst_n_in && rv) begin
         chk({re, rd}, rq.size() ? rq.pop_front() : ~{re, rd}, "receive nibble");
      end
      if (rst_n_in && ltv) begin
         chk({lte, ltd}, tq.size() ? tq.pop_front() : ~{lte, ltd}, "transmit nibble");
      end
   end
   task print_verdict();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Cuts a hang short well past the expected run length
   initial begin
      #400000;
      n_errors++;
      print_verdict();
   end
   // Every mode at both speeds, each after a fresh reset since mode is static
   initial begin
      {clk_in, rst_n_in, slow, fdx, rdv, rerr, tv, terr} = '0;
      {rdat, td} = '0;
      mode = MODE_MII;
      link.strap_level = 5'h01;
      void'($urandom(80));
      for (int p = 0; p < 6; p++) begin
         #1 rst_n_in = 1'b0;
         repeat (10) @(posedge clk_in);
         #1;
         mode = port_mode_type'(p / 2);
         slow = p[0];
         fdx = 1'($urandom);
         link.strap_level = (p == 0) ? 5'h01 : 5'($urandom);
         rst_n_in = 1'b1;
         wait (done);
         @(negedge clk_in);
         chk(addr, link.strap_level, "strap address");
         @(posedge clk_in);
         #1;
         fork
            run_rx();
            run_tx();
         join
         wait (rq.size() == 0 && tq.size() == 0);
         repeat (100) @(posedge clk_in);
         // Idle link: no carrier; collision pin low, or its pull level in RMII
         chk({3'h0, crs_o, col_o}, {4'h0, (mode == MODE_RMII) & link.strap_level[0]},
            "idle carrier and collision");
         $display("test mode %0d slow %0d done", p / 2, p % 2);
      end
      print_verdict();
   end
endmodule
